//--- rtl/switch_irq_pkg.sv
// Constants for the switch interrupt mask and ACL event block.
// Assumes a 32-bit APB master; register indices are scaled by four into byte addresses.
package switch_irq_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LINK_PORTS = 4;
    localparam int ACL_PORTS = 5;
    localparam int FIELD_W = 5;
    localparam int REG_W = 8;
    // Register indices as printed, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_INT_STATUS = 12'h07C;
    localparam logic [ADDR_W-1:0] IDX_INT_MASK = 12'h07D;
    localparam logic [ADDR_W-1:0] IDX_ACL_FLAGS = 12'h07E;
    localparam logic [ADDR_W-1:0] IDX_ACL_ENABLES = 12'h07F;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = IDX_INT_STATUS << 2;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK = IDX_INT_MASK << 2;
    localparam logic [ADDR_W-1:0] ADDR_ACL_FLAGS = IDX_ACL_FLAGS << 2;
    localparam logic [ADDR_W-1:0] ADDR_ACL_ENABLES = IDX_ACL_ENABLES << 2;
    // Field positions
    localparam int PORT1_BIT = 0;
    localparam int PORT4_BIT = 3;
    localparam int WAKE_BIT = 4;
    // Reset values
    localparam logic [FIELD_W-1:0] STATUS_RESET = 5'h00;
    localparam logic [FIELD_W-1:0] MASK_RESET = 5'h00;
    localparam logic [ACL_PORTS-1:0] ACL_FLAGS_RESET = 5'h00;
    localparam logic [ACL_PORTS-1:0] ACL_ENABLES_RESET = 5'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
endpackage

//--- rtl/switch_irq_ctrl.sv
// Interrupt status, mask and ACL event registers of a five-port switch, on APB.
// Assumes link, wake and ACL inputs are synchronous to CLK_IN; zero-wait APB slave.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module switch_irq_ctrl
    import switch_irq_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic [DATA_W-1:0] PWDATA_IN,
    output logic [DATA_W-1:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Event sources
    input wire logic [LINK_PORTS-1:0] LINK_UP_IN,
    input wire logic WAKE_EVENT_IN,
    input wire logic [ACL_PORTS-1:0] ACL_EVENT_IN,
    // Interrupt request
    output logic IRQ_OUT
);

    logic [FIELD_W-1:0] interrupt_status;
    logic [FIELD_W-1:0] interrupt_enable_mask;
    logic [ACL_PORTS-1:0] acl_event_flag_field;
    logic [ACL_PORTS-1:0] acl_event_enable_field;
    logic [LINK_PORTS-1:0] link_prev;
    logic primed;
    logic [LINK_PORTS-1:0] link_change;
    logic [FIELD_W-1:0] status_set;
    logic [FIELD_W-1:0] status_clr;
    logic [ACL_PORTS-1:0] acl_clr;
    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic hit_status;
    logic hit_mask;
    logic hit_acl_flags;
    logic hit_acl_en;
    logic mapped;
    logic [DATA_W-1:0] next_rdata;

    assign setup_phase = PSEL_IN && !PENABLE_IN;
    assign access_phase = PSEL_IN && PENABLE_IN;
    assign wr_en = access_phase && PWRITE_IN;

    // Address decode
    always_comb begin
        hit_status = 1'b0;
        hit_mask = 1'b0;
        hit_acl_flags = 1'b0;
        hit_acl_en = 1'b0;
        if (PADDR_IN == ADDR_INT_STATUS) begin
            hit_status = 1'b1;
        end else if (PADDR_IN == ADDR_INT_MASK) begin
            hit_mask = 1'b1;
        end else if (PADDR_IN == ADDR_ACL_FLAGS) begin
            hit_acl_flags = 1'b1;
        end else if (PADDR_IN == ADDR_ACL_ENABLES) begin
            hit_acl_en = 1'b1;
        end
    end

    assign mapped = hit_status || hit_mask || hit_acl_flags || hit_acl_en;

    // Zero wait state; every access ends in its first access cycle
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access_phase && !mapped;

    // Link history is only trusted one cycle after reset, so a link
    // already up at release does not raise a spurious change
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            link_prev <= '0;
            primed <= 1'b0;
        end else begin
            link_prev <= LINK_UP_IN;
            primed <= 1'b1;
        end
    end

    assign link_change = primed ? (LINK_UP_IN ^ link_prev) : '0;

    genvar g;
    generate
        for (g = 0; g < LINK_PORTS; g++) begin : g_port
            assign status_set[g] = link_change[g];
            assign status_clr[g] = wr_en && hit_status && PWDATA_IN[g];
        end
    endgenerate

    assign status_set[WAKE_BIT] = WAKE_EVENT_IN;
    assign status_clr[WAKE_BIT] = wr_en && hit_status && PWDATA_IN[WAKE_BIT];

    // sticky status, write-one-to-clear
    // Set wins over a clear landing in the same cycle, so no event is lost
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            interrupt_status <= STATUS_RESET;
        end else begin
            interrupt_status <= (interrupt_status & ~status_clr) | status_set;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            interrupt_enable_mask <= MASK_RESET;
        end else if (wr_en && hit_mask) begin
            interrupt_enable_mask <= PWDATA_IN[FIELD_W-1:0];
        end
    end

    // ACL flags sticky
    // Flags are not writable as data; a written one only acknowledges
    assign acl_clr = (wr_en && hit_acl_flags) ? PWDATA_IN[ACL_PORTS-1:0] : '0;

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            acl_event_flag_field <= ACL_FLAGS_RESET;
        end else begin
            acl_event_flag_field <= (acl_event_flag_field & ~acl_clr) | ACL_EVENT_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            acl_event_enable_field <= ACL_ENABLES_RESET;
        end else if (wr_en && hit_acl_en) begin
            acl_event_enable_field <= PWDATA_IN[ACL_PORTS-1:0];
        end
    end

    // Read data captured in setup so it stands from a flop during access
    always_comb begin
        next_rdata = RDATA_RESET;
        if (hit_status) begin
            next_rdata[FIELD_W-1:0] = interrupt_status;
        end else if (hit_mask) begin
            next_rdata[FIELD_W-1:0] = interrupt_enable_mask;
        end else if (hit_acl_flags) begin
            next_rdata[ACL_PORTS-1:0] = acl_event_flag_field;
        end else if (hit_acl_en) begin
            next_rdata[ACL_PORTS-1:0] = acl_event_enable_field;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT <= RDATA_RESET;
        end else if (setup_phase && !PWRITE_IN) begin
            PRDATA_OUT <= next_rdata;
        end
    end

    // masked interrupt request
    // Registered so the pin never glitches on decode changes
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |({interrupt_status & interrupt_enable_mask,
                          acl_event_flag_field & acl_event_enable_field});
        end
    end

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    // Port 1 change reaches its status bit next cycle
    port1_set_a: assert property (
        link_change[PORT1_BIT] |=> interrupt_status[PORT1_BIT])
        else $error("port 1 link change not recorded");

    // Port 1 bit holds until a one is written to it
    port1_hold_a: assert property (
        interrupt_status[PORT1_BIT] && !(wr_en && hit_status && PWDATA_IN[PORT1_BIT])
        |=> interrupt_status[PORT1_BIT])
        else $error("port 1 status lost without clear");

    // A written one clears port 1 when no change lands with it
    port1_clear_a: assert property (
        wr_en && hit_status && PWDATA_IN[PORT1_BIT] && !link_change[PORT1_BIT]
        |=> !interrupt_status[PORT1_BIT])
        else $error("port 1 status not cleared");

    // Status read returns the flags captured at setup
    status_read_a: assert property (
        setup_phase && !PWRITE_IN && hit_status
        |=> PRDATA_OUT == {{(DATA_W-FIELD_W){1'b0}}, $past(interrupt_status)})
        else $error("status read data wrong");

    // Wake mask bit follows a write of bit 4
    wake_mask_a: assert property (
        wr_en && hit_mask |=> interrupt_enable_mask[WAKE_BIT] == $past(PWDATA_IN[WAKE_BIT]))
        else $error("wake mask bit not written");

    // Port mask bits follow a write of bits 3 to 0
    port_mask_a: assert property (
        wr_en && hit_mask
        |=> interrupt_enable_mask[PORT4_BIT:PORT1_BIT] == $past(PWDATA_IN[PORT4_BIT:PORT1_BIT]))
        else $error("port mask bits not written");

    // Mask is zero when reset is released
    mask_reset_a: assert property (@(posedge CLK_IN)
        $fell(RESET_IN) |-> interrupt_enable_mask == MASK_RESET)
        else $error("mask not cleared by reset");

    // ACL flags and enables clear on reset
    acl_reset_a: assert property (@(posedge CLK_IN)
        $fell(RESET_IN) |-> acl_event_flag_field == ACL_FLAGS_RESET)
        else $error("acl flags not cleared by reset");

    acl_en_reset_a: assert property (@(posedge CLK_IN)
        $fell(RESET_IN) |-> acl_event_enable_field == ACL_ENABLES_RESET)
        else $error("acl enables not cleared by reset");

    // ACL flag raised one cycle after its event
    acl_set_a: assert property (
        ACL_EVENT_IN != '0 |=> (acl_event_flag_field & $past(ACL_EVENT_IN)) == $past(ACL_EVENT_IN))
        else $error("acl event not flagged");

    // ACL flag 0 never rises without its event
    acl_cause_a: assert property (
        $rose(acl_event_flag_field[0]) |-> $past(ACL_EVENT_IN[0]))
        else $error("acl flag set without event");

    // A bus write never raises an ACL flag
    acl_write_a: assert property (
        wr_en && hit_acl_flags && ACL_EVENT_IN == '0
        |=> (acl_event_flag_field & ~$past(acl_event_flag_field)) == '0)
        else $error("acl flag set by a write");

    // ACL enable field takes written value
    acl_enable_a: assert property (
        wr_en && hit_acl_en |=> acl_event_enable_field == $past(PWDATA_IN[ACL_PORTS-1:0]))
        else $error("acl enable not written");

    // Ports 2 to 4 record link changes
    port_upper_a: assert property (
        |link_change[PORT4_BIT:1] |=> (interrupt_status[PORT4_BIT:1] & $past(link_change[PORT4_BIT:1]))
        == $past(link_change[PORT4_BIT:1]))
        else $error("port 2 to 4 change not recorded");

    // Wake event sets bit 4 even against a clear
    wake_set_a: assert property (
        WAKE_EVENT_IN |=> interrupt_status[WAKE_BIT])
        else $error("wake event not recorded");

    // Wake bit clears on a written one only without a new event
    wake_clear_a: assert property (
        wr_en && hit_status && PWDATA_IN[WAKE_BIT] && !WAKE_EVENT_IN |=> !interrupt_status[WAKE_BIT])
        else $error("wake status not cleared");

    // Interrupt follows enabled status by one cycle
    irq_level_a: assert property (
        |(interrupt_status & interrupt_enable_mask) |=> IRQ_OUT)
        else $error("interrupt missing while enabled status set");

    // Enabled ACL flag raises the interrupt next cycle
    acl_irq_a: assert property (
        |(acl_event_flag_field & acl_event_enable_field) |=> IRQ_OUT)
        else $error("interrupt missing while enabled acl flag set");

    // No interrupt without an enabled cause
    irq_cause_a: assert property (
        IRQ_OUT |-> $past(|({interrupt_status & interrupt_enable_mask,
                             acl_event_flag_field & acl_event_enable_field})))
        else $error("interrupt without enabled cause");

    // Interrupt drops once no enabled cause remains
    irq_drop_a: assert property (
        !(|({interrupt_status & interrupt_enable_mask, acl_event_flag_field & acl_event_enable_field}))
        |=> !IRQ_OUT)
        else $error("interrupt held without enabled cause");

    // Unmapped access reports an error, mapped never does
    bus_error_a: assert property (
        access_phase && PADDR_IN != ADDR_INT_STATUS && PADDR_IN != ADDR_INT_MASK
        && PADDR_IN != ADDR_ACL_FLAGS && PADDR_IN != ADDR_ACL_ENABLES |-> PSLVERR_OUT)
        else $error("unmapped access without error");

    bus_ok_a: assert property (
        PSLVERR_OUT |-> access_phase && PADDR_IN != ADDR_INT_STATUS && PADDR_IN != ADDR_INT_MASK
        && PADDR_IN != ADDR_ACL_FLAGS && PADDR_IN != ADDR_ACL_ENABLES)
        else $error("error response on a mapped or idle cycle");

endmodule
`default_nettype wire

//--- bench/switch_interrupt_mask_and_acl_events_tb.sv
// Self-checking bench for the switch interrupt status, mask and ACL event registers.
// Assumes switch_irq_ctrl is a zero-wait APB slave with registered status and interrupt.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module switch_interrupt_mask_and_acl_events_tb
    import switch_irq_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, wake;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdata;
    logic [LINK_PORTS-1:0] link;
    logic [ACL_PORTS-1:0] acl;
    logic slverr;
    int error_cnt = 0;
    int check_count = 0;

    switch_irq_ctrl u_dut (
        .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINK_UP_IN(link),
        .WAKE_EVENT_IN(wake), .ACL_EVENT_IN(acl), .IRQ_OUT(irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(1'b0, a, 32'h00000000);
        `CHK("read data", exp, rdata)
    endtask

    task automatic reset_values();
        rd_chk(ADDR_INT_MASK, 32'h00000000);
        rd_chk(ADDR_ACL_FLAGS, 32'h00000000);
        rd_chk(ADDR_ACL_ENABLES, 32'h00000000);
        rd_chk(ADDR_INT_STATUS, 32'h00000000);
        `CHK("error on mapped read", 1'b0, slverr)
        `CHK("irq after reset", 1'b0, irq)
    endtask

    task automatic enables_rw();
        apb(1'b1, ADDR_INT_MASK, 32'hFFFFFFFF);
        rd_chk(ADDR_INT_MASK, 32'h0000001F);
        apb(1'b1, ADDR_ACL_ENABLES, 32'hFFFFFFFF);
        rd_chk(ADDR_ACL_ENABLES, 32'h0000001F);
        apb(1'b1, ADDR_INT_MASK, 32'h00000000);
        apb(1'b1, ADDR_ACL_ENABLES, 32'h00000000);
        rd_chk(ADDR_INT_MASK, 32'h00000000);
        rd_chk(ADDR_ACL_ENABLES, 32'h00000000);
        apb(1'b1, ADDR_ACL_FLAGS, 32'hFFFFFFFF);
        `CHK("error on mapped write", 1'b0, slverr)
        rd_chk(ADDR_ACL_FLAGS, 32'h00000000);
    endtask

    // Event and clear at one edge: the event wins
    task automatic set_wins();
        fork
            apb(1'b1, ADDR_INT_STATUS, 32'h00000011);
            begin
                @(posedge clk);
                link[0] <= ~link[0];
                wake <= 1'b1;
                @(posedge clk);
                wake <= 1'b0;
            end
        join
        rd_chk(ADDR_INT_STATUS, 32'h00000011);
        fork
            apb(1'b1, ADDR_ACL_FLAGS, 32'h00000001);
            begin
                @(posedge clk);
                acl[0] <= 1'b1;
                @(posedge clk);
                acl <= '0;
            end
        join
        rd_chk(ADDR_ACL_FLAGS, 32'h00000001);
        apb(1'b1, ADDR_INT_STATUS, 32'h00000011);
        apb(1'b1, ADDR_ACL_FLAGS, 32'h00000001);
        rd_chk(ADDR_INT_STATUS, 32'h00000000);
        rd_chk(ADDR_ACL_FLAGS, 32'h00000000);
    endtask

    // Reset in mid-run with state set and port 1 link up; links must not look changed
    task automatic reset_midrun();
        apb(1'b1, ADDR_INT_MASK, 32'h0000001F);
        apb(1'b1, ADDR_ACL_ENABLES, 32'h0000001F);
        link <= ~link;
        acl <= 5'h1F;
        @(posedge clk);
        acl <= '0;
        repeat (3) @(posedge clk);
        `CHK("irq before mid reset", 1'b1, irq)
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("irq after mid reset", 1'b0, irq)
        rd_chk(ADDR_INT_MASK, 32'h00000000);
        rd_chk(ADDR_ACL_ENABLES, 32'h00000000);
        rd_chk(ADDR_ACL_FLAGS, 32'h00000000);
        rd_chk(ADDR_INT_STATUS, 32'h00000000);
    endtask

    // Kind 0 link change, 1 wake, 2 ACL; flag must stay until written one
    task automatic event_chk(input int kind, input int p);
        logic [ADDR_W-1:0] sa, ma;
        logic [DATA_W-1:0] bv;
        sa = (kind == 2) ? ADDR_ACL_FLAGS : ADDR_INT_STATUS;
        ma = (kind == 2) ? ADDR_ACL_ENABLES : ADDR_INT_MASK;
        bv = 32'h00000001 << p;
        if (kind == 0) link[p] <= ~link[p];
        else if (kind == 1) wake <= 1'b1;
        else acl[p] <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        acl <= '0;
        repeat (3) @(posedge clk);
        rd_chk(sa, bv);
        `CHK("irq while masked", 1'b0, irq)
        apb(1'b1, ma, bv);
        repeat (2) @(posedge clk);
        `CHK("irq enabled", 1'b1, irq)
        rd_chk(sa, bv);
        apb(1'b1, sa, bv);
        repeat (2) @(posedge clk);
        `CHK("irq after clear", 1'b0, irq)
        rd_chk(sa, 32'h00000000);
        apb(1'b1, ma, 32'h00000000);
    endtask

    task automatic unmapped();
        apb(1'b1, 12'h100, 32'hFFFFFFFF);
        `CHK("error on write", 1'b1, slverr)
        rd_chk(12'h100, 32'h00000000);
        `CHK("error on read", 1'b1, slverr)
        rd_chk(ADDR_INT_MASK, 32'h00000000);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        link = '0;
        wake = 1'b0;
        acl = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reset_values();
        enables_rw();
        for (int p = 0; p < LINK_PORTS; p++) event_chk(0, p);
        event_chk(1, WAKE_BIT);
        for (int p = 0; p < ACL_PORTS; p++) event_chk(2, p);
        set_wins();
        reset_midrun();
        unmapped();
        final_report();
    end
endmodule
`default_nettype wire
